// [src/fifo_port_pkg.sv]
// package for the dual-clock fifo port controller: pin map, config carrier, register map
// assumes one system clock samples every pin, including both link clocks
package fifo_port_pkg;

  // ==========================================================================
  // sampled pin vector layout
  localparam int P_MRS = 0;
  localparam int P_ICLK = 1;
  localparam int P_OCLK = 2;
  localparam int P_WEN = 3;
  localparam int P_REN = 4;
  localparam int P_SI = 5;
  localparam int P_SEN = 6;
  localparam int P_LD = 7;
  localparam int P_OE = 8;
  localparam int P_PICK0 = 9;
  localparam int P_PICK1 = 10;
  localparam int P_BM = 11;
  localparam int P_IW = 12;
  localparam int P_OW = 13;
  localparam int P_BE = 14;
  localparam int P_ASYNC_INPUT_PORT_SELECT = 15;
  localparam int P_ASYNC_OUTPUT_PORT_SELECT = 16;
  localparam int P_DATA = 17;
  localparam int WORD_W = 36;
  localparam int PIN_W = P_DATA + WORD_W;

  // ==========================================================================
  // configuration caught while master reset is held
  typedef struct packed {
    logic fall_through;
    logic serial_load;
    logic [2:0] pick;
    logic [1:0] in_code;
    logic [1:0] out_code;
    logic little_end;
    logic async_wr;
    logic async_rd;
  } cfg_t;
  localparam cfg_t CFG_RESET = '0;

  // ==========================================================================
  // register map and status fields
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_EMPTY_OFF = 8'h04;
  localparam logic [7:0] ADDR_FULL_OFF = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_FWFT_BIT = 16;
  localparam int ST_SERIAL_BIT = 17;
  localparam int ST_EMPTY_BIT = 18;
  localparam int ST_FULL_BIT = 19;

  // default almost-empty / almost-full offsets, chosen by {load, pick1, pick0}
  localparam logic [15:0] DEFAULT_OFFSET [8] = '{16'h0007, 16'h000f, 16'h001f, 16'h003f,
                                                 16'h007f, 16'h00ff, 16'h01ff, 16'h03ff};
endpackage : fifo_port_pkg

// [src/fifo_port_ctrl.sv]
// dual-clock fifo write/read port control, all logic on clock_in
// assumes input_clock and output_clock arrive as pins, far slower than clock_in
//
// Functional notes
// - fall-through pin at reset picks flag mode
// - standard mode: every word needs read request
// - fall-through: first word shows after three edges in sync read mode
// - after reset, pin shifts serial offset data
// - write enable low and not full stores
// - write enable high stores nothing
// - idle input clock freezes almost-full, and full in sync write mode
// - async strobe rising edge writes input word
// - full flag returns two input edges later in sync write mode
// - input ready returns two input edges later in sync write mode
// - full memory ignores write enable
// - read enable loads output register, else holds
// - idle output clock freezes almost-empty, and empty in sync read mode
// - async strobe rising edge reads a word
// - empty flag blocks reads, returns two edges in standard sync read mode
// - fall-through ready rises only on true read
// - serial enable and load shift one bit
// - output enable low drives bus, else released
// - reset load and picks select default offsets
// - load low opens offset access, chosen method
// - bus widths latched at reset, flags follow
// - byte order picks which end piece leaves first
// - master reset clears pointers, output, latches config
`timescale 1ns/1ps
`default_nettype none
module fifo_port_ctrl import fifo_port_pkg::*; #(
  parameter int DEPTH = 1024,
  parameter int OFF_W = 16
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic master_reset_n_in,
  input wire logic input_clock_in,
  input wire logic output_clock_in,
  input wire logic write_enable_n_in,
  input wire logic read_enable_n_in,
  input wire logic [WORD_W-1:0] input_bus_in,
  input wire logic fall_through_serial_in_in,
  input wire logic serial_program_enable_n_in,
  input wire logic offset_load_strobe_n_in,
  input wire logic offset_default_pick0_in,
  input wire logic offset_default_pick1_in,
  input wire logic bus_match_select_in,
  input wire logic input_width_select_in,
  input wire logic output_width_select_in,
  input wire logic byte_order_select_in,
  input wire logic async_input_port_select_n_in,
  input wire logic async_output_port_select_n_in,
  input wire logic output_drive_enable_n_in,
  output logic [WORD_W-1:0] output_bus_out,
  output logic output_bus_oe_out,
  output logic empty_flag_n_out,
  output logic full_flag_n_out,
  output logic almost_empty_flag_n_out,
  output logic almost_full_flag_n_out,
  output logic half_level_flag_n_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int PTR_W = ADDR_W + 1;
  localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
  localparam logic [PTR_W-1:0] HALF_P = PTR_W'(DEPTH / 2);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || OFF_W < ADDR_W || OFF_W > 16) begin : g_bad
    $error("depth must be a power of two and offsets must fit 16 bits");
  end

  // ==========================================================================
  // piece helpers for bus matching
  function automatic logic [WORD_W-1:0] piece_mask(input logic [1:0] code);
    piece_mask = (code == 2'h0) ? 36'hfffffffff : (code == 2'h1) ? 36'h00003ffff : 36'h0000001ff;
  endfunction : piece_mask

  function automatic int piece_shift(input logic [1:0] code, input logic [1:0] idx, input logic little);
    int n;
    n = (code == 2'h0) ? 1 : (code == 2'h1) ? 2 : 4;
    piece_shift = (little ? int'(idx) : n - 1 - int'(idx)) * (WORD_W / n);
  endfunction : piece_shift

  function automatic logic [1:0] last_idx(input logic [1:0] code);
    last_idx = (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
  endfunction : last_idx

  // ==========================================================================
  // pin synchroniser: three stages, a change counts once stages two and three agree
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q, prev_q;
  assign pins_raw = {input_bus_in, async_output_port_select_n_in, async_input_port_select_n_in,
                     byte_order_select_in, output_width_select_in, input_width_select_in,
                     bus_match_select_in, offset_default_pick1_in, offset_default_pick0_in,
                     output_drive_enable_n_in, offset_load_strobe_n_in, serial_program_enable_n_in,
                     fall_through_serial_in_in, read_enable_n_in, write_enable_n_in,
                     output_clock_in, input_clock_in, master_reset_n_in};

  for (genvar b = 0; b < PIN_W; b++) begin : g_sync
    always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        s1_q[b] <= 1'b0;
        s2_q[b] <= 1'b0;
        s3_q[b] <= 1'b0;
        pin_q[b] <= 1'b0;
        prev_q[b] <= 1'b0;
      end else begin
        s1_q[b] <= pins_raw[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b]) begin
          pin_q[b] <= s3_q[b];
        end
        prev_q[b] <= pin_q[b];
      end
    end
  end

  logic mrs_active, wclk_rise, rclk_rise;
  logic [WORD_W-1:0] din;
  assign mrs_active = ~pin_q[P_MRS];
  assign wclk_rise = pin_q[P_ICLK] & ~prev_q[P_ICLK];
  assign rclk_rise = pin_q[P_OCLK] & ~prev_q[P_OCLK];
  assign din = pin_q[P_DATA +: WORD_W];

  // ==========================================================================
  // configuration latch
  cfg_t cfg_q;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= CFG_RESET;
    end else if (mrs_active) begin
      cfg_q.fall_through <= pin_q[P_SI];
      cfg_q.serial_load <= pin_q[P_LD];
      cfg_q.pick <= {pin_q[P_LD], pin_q[P_PICK1], pin_q[P_PICK0]};
      cfg_q.in_code <= (pin_q[P_BM] & pin_q[P_IW]) ? (pin_q[P_OW] ? 2'h2 : 2'h1) : 2'h0;
      cfg_q.out_code <= (pin_q[P_BM] & ~pin_q[P_IW]) ? (pin_q[P_OW] ? 2'h2 : 2'h1) : 2'h0;
      cfg_q.little_end <= pin_q[P_BE];
      cfg_q.async_wr <= ~pin_q[P_ASYNC_INPUT_PORT_SELECT];
      cfg_q.async_rd <= ~pin_q[P_ASYNC_OUTPUT_PORT_SELECT];
    end
  end

  // ==========================================================================
  // memory and pointers
  logic [WORD_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr_q, rptr_q, rsync1_q, rsync2_q, wsync1_q, wsync2_q;
  logic [PTR_W-1:0] rptr_seen, wptr_seen, wcount, rcount, wcount_d, rcount_d, wcount_post, rcount_post;
  logic [WORD_W-1:0] acc_q, acc_d;
  logic [1:0] in_idx_q;
  logic wr_event, commit, full_now;

  assign rptr_seen = cfg_q.async_wr ? rptr_q : rsync2_q;
  assign wptr_seen = cfg_q.async_rd ? wptr_q : wsync2_q;
  assign wcount = wptr_q - rptr_seen;
  assign full_now = (wcount == DEPTH_P);
  assign wr_event = wclk_rise & ~pin_q[P_WEN] & ~mrs_active & ~full_now;
  assign acc_d = (acc_q & ~(piece_mask(cfg_q.in_code) << piece_shift(cfg_q.in_code, in_idx_q, cfg_q.little_end)))
                 | ((din & piece_mask(cfg_q.in_code)) << piece_shift(cfg_q.in_code, in_idx_q, cfg_q.little_end));
  assign commit = wr_event & (in_idx_q == last_idx(cfg_q.in_code));
  assign wcount_d = wcount + PTR_W'(commit);
  assign wcount_post = wptr_q + PTR_W'(commit) - (cfg_q.async_wr ? rptr_q : rsync1_q);

  always_ff @(posedge clock_in) begin
    if (commit) begin
      mem[wptr_q[ADDR_W-1:0]] <= acc_d;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr_q <= '0;
      acc_q <= '0;
      in_idx_q <= 2'h0;
      rsync1_q <= '0;
      rsync2_q <= '0;
    end else if (mrs_active) begin
      wptr_q <= '0;
      acc_q <= '0;
      in_idx_q <= 2'h0;
      rsync1_q <= '0;
      rsync2_q <= '0;
    end else begin
      if (wclk_rise) begin
        rsync1_q <= rptr_q;
        rsync2_q <= rsync1_q;
      end
      if (commit) begin
        wptr_q <= wptr_q + PTR_W'(1);
        acc_q <= '0;
        in_idx_q <= 2'h0;
      end else if (wr_event) begin
        acc_q <= acc_d;
        in_idx_q <= in_idx_q + 2'h1;
      end
    end
  end

  // ==========================================================================
  // read side
  logic [WORD_W-1:0] out_word_q, out_word_d;
  logic [1:0] out_idx_q, out_idx_d;
  logic loaded_q, loaded_d, valid_q, valid_d, pop, more_pieces, rd_req;
  logic [PTR_W-1:0] rptr_d;

  assign rcount = wptr_seen - rptr_q;
  assign more_pieces = loaded_q & (out_idx_q != last_idx(cfg_q.out_code));
  assign rd_req = rclk_rise & ~pin_q[P_REN] & ~mrs_active;

  always_comb begin
    pop = 1'b0;
    out_idx_d = out_idx_q;
    loaded_d = loaded_q;
    valid_d = valid_q;
    if (!cfg_q.fall_through) begin
      if (rd_req && more_pieces) begin
        out_idx_d = out_idx_q + 2'h1;
      end else if (rd_req && rcount != '0) begin
        pop = 1'b1;
      end
    end else if (rclk_rise && !mrs_active) begin
      if (valid_q && rd_req && more_pieces) begin
        out_idx_d = out_idx_q + 2'h1;
      end else if ((!valid_q || rd_req) && rcount != '0) begin
        pop = 1'b1;
        valid_d = 1'b1;
      end else if (rd_req) begin
        valid_d = 1'b0;
      end
    end
    if (pop) begin
      out_idx_d = 2'h0;
      loaded_d = 1'b1;
    end
    out_word_d = pop ? mem[rptr_q[ADDR_W-1:0]] : out_word_q;
    rptr_d = rptr_q + PTR_W'(pop);
    rcount_d = rcount - PTR_W'(pop);
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rptr_q <= '0;
      out_word_q <= '0;
      out_idx_q <= 2'h0;
      loaded_q <= 1'b0;
      valid_q <= 1'b0;
      output_bus_out <= '0;
      wsync1_q <= '0;
      wsync2_q <= '0;
    end else if (mrs_active) begin
      rptr_q <= '0;
      out_word_q <= '0;
      out_idx_q <= 2'h0;
      loaded_q <= 1'b0;
      valid_q <= 1'b0;
      output_bus_out <= '0;
      wsync1_q <= '0;
      wsync2_q <= '0;
    end else begin
      if (rclk_rise) begin
        wsync1_q <= wptr_q;
        wsync2_q <= wsync1_q;
      end
      rptr_q <= rptr_d;
      out_word_q <= out_word_d;
      out_idx_q <= out_idx_d;
      loaded_q <= loaded_d;
      valid_q <= valid_d;
      output_bus_out <= (out_word_d >> piece_shift(cfg_q.out_code, out_idx_d, cfg_q.little_end))
                        & piece_mask(cfg_q.out_code);
    end
  end

  // ==========================================================================
  // status flags on link clock edges; half uses both edges, async full and empty update every cycle
  logic [OFF_W-1:0] empty_off_q, full_off_q;
  logic avail_d;
  assign rcount_post = (cfg_q.async_rd ? wptr_q : wsync1_q) - rptr_d;
  assign avail_d = (rcount_post != '0) | (loaded_d & (out_idx_d != last_idx(cfg_q.out_code)));

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      full_flag_n_out <= 1'b1;
      empty_flag_n_out <= 1'b0;
      almost_full_flag_n_out <= 1'b1;
      almost_empty_flag_n_out <= 1'b0;
      half_level_flag_n_out <= 1'b1;
    end else if (mrs_active) begin
      full_flag_n_out <= ~pin_q[P_SI];
      empty_flag_n_out <= pin_q[P_SI];
      almost_full_flag_n_out <= 1'b1;
      almost_empty_flag_n_out <= 1'b0;
      half_level_flag_n_out <= 1'b1;
    end else begin
      if (wclk_rise || cfg_q.async_wr) begin
        full_flag_n_out <= cfg_q.fall_through ? (wcount_post == DEPTH_P) : (wcount_post != DEPTH_P);
      end
      if (wclk_rise) begin
        almost_full_flag_n_out <= ~(wcount_d >= DEPTH_P - PTR_W'(full_off_q));
      end
      if (rclk_rise || cfg_q.async_rd) begin
        empty_flag_n_out <= cfg_q.fall_through ? ~valid_d : avail_d;
      end
      if (rclk_rise) begin
        almost_empty_flag_n_out <= ~(rcount_d <= PTR_W'(empty_off_q));
      end
      if (wclk_rise && wcount_d > HALF_P) begin
        half_level_flag_n_out <= 1'b0;
      end else if (rclk_rise && rcount_d <= HALF_P) begin
        half_level_flag_n_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      output_bus_oe_out <= 1'b0;
    end else begin
      output_bus_oe_out <= ~pin_q[P_OE];
    end
  end

  // ==========================================================================
  // offset registers: defaults, serial shift, parallel bus access
  logic aw_have_q, w_have_q, bus_wr;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic par_ok;
  logic [15:0] merged;
  assign bus_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign par_ok = ~cfg_q.serial_load & ~pin_q[P_LD] & ~mrs_active;
  assign merged = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      empty_off_q <= '0;
      full_off_q <= '0;
    end else if (mrs_active) begin
      empty_off_q <= OFF_W'(DEFAULT_OFFSET[{pin_q[P_LD], pin_q[P_PICK1], pin_q[P_PICK0]}]);
      full_off_q <= OFF_W'(DEFAULT_OFFSET[{pin_q[P_LD], pin_q[P_PICK1], pin_q[P_PICK0]}]);
    end else if (cfg_q.serial_load && wclk_rise && !pin_q[P_SEN] && !pin_q[P_LD]) begin
      {full_off_q, empty_off_q} <= {full_off_q[OFF_W-2:0], empty_off_q, pin_q[P_SI]};
    end else if (bus_wr && par_ok && awaddr_q == ADDR_EMPTY_OFF) begin
      empty_off_q <= OFF_W'(merged);
    end else if (bus_wr && par_ok && awaddr_q == ADDR_FULL_OFF) begin
      full_off_q <= OFF_W'(merged);
    end
  end

  // ==========================================================================
  // axi4-lite slave
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (bus_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == ADDR_EMPTY_OFF || awaddr_q == ADDR_FULL_OFF) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= '0;
        case (s_axi_araddr)
          ADDR_STATUS: begin
            s_axi_rdata[ST_COUNT_LSB +: 16] <= 16'(wcount);
            s_axi_rdata[ST_FWFT_BIT] <= cfg_q.fall_through;
            s_axi_rdata[ST_SERIAL_BIT] <= cfg_q.serial_load;
            s_axi_rdata[ST_EMPTY_BIT] <= empty_flag_n_out;
            s_axi_rdata[ST_FULL_BIT] <= full_flag_n_out;
          end
          ADDR_EMPTY_OFF: s_axi_rdata[15:0] <= 16'(empty_off_q);
          ADDR_FULL_OFF: s_axi_rdata[15:0] <= 16'(full_off_q);
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  chk_std_read_request: assert property (!cfg_q.fall_through && !$past(mrs_active) && rptr_q != $past(rptr_q)
    |-> $past(rd_req)) else $error("standard mode popped without a read request");
  chk_wen_high_block: assert property (wclk_rise && pin_q[P_WEN] && !mrs_active |=> wptr_q == $past(wptr_q))
    else $error("write pointer moved with write enable high");
  chk_full_no_write: assert property (full_now && !mrs_active |=> wptr_q == $past(wptr_q))
    else $error("write stored into a full memory");
  chk_empty_no_read: assert property (!cfg_q.fall_through && !mrs_active && rcount == '0 && !more_pieces
    |=> $stable(out_word_q))
    else $error("output register changed while empty");
  chk_oe_follows_pin: assert property ($past(arst_n_in) |=> output_bus_oe_out == !$past(pin_q[P_OE]))
    else $error("output enable does not follow its pin");
  chk_serial_hold: assert property (pin_q[P_SEN] && !bus_wr && !mrs_active |=> $stable(empty_off_q))
    else $error("offset changed with serial enable high");
  chk_full_on_wclk: assert property (!cfg_q.async_wr && !$past(mrs_active) && $changed(full_flag_n_out)
    |-> $past(wclk_rise)) else $error("full flag moved without an input clock edge");
  chk_half_direction: assert property ($fell(half_level_flag_n_out) && !$past(mrs_active) |-> $past(wclk_rise))
    else $error("half flag fell without an input clock edge");
  chk_fwft_sync_path: assert property (cfg_q.fall_through && !cfg_q.async_rd && $rose(valid_q)
    |-> $past(wsync2_q != rptr_q) && $past(rclk_rise)) else $error("word fell through before synchroniser");
endmodule : fifo_port_ctrl
`default_nettype wire

// [testbench/far_side_model.sv]
// far side model: upstream writer and downstream reader that make the link clocks
// assumes clock_in of 50 ns; one link period is 8 clock_in cycles (400 ns)
`timescale 1ns/1ps
`default_nettype none
module far_side_model import fifo_port_pkg::*; (
  input wire logic clock_in,
  output logic in_clk_out,
  output logic out_clk_out,
  output logic wen_n_out,
  output logic ren_n_out,
  output logic [WORD_W-1:0] data_out
);
  // ==========================================================================
  // one link cycle per call; clocks stand still between calls
  initial begin
    in_clk_out = 1'b0;
    out_clk_out = 1'b0;
    wen_n_out = 1'b1;
    ren_n_out = 1'b1;
    data_out = '0;
  end
  task automatic wr_cycle(input logic en_n, input logic [WORD_W-1:0] d);
    @(posedge clock_in);
    wen_n_out <= en_n;
    data_out <= d;
    @(posedge clock_in);
    in_clk_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    in_clk_out <= 1'b0;
    data_out <= ~d;
    repeat (2) @(posedge clock_in);
  endtask : wr_cycle
  task automatic rd_cycle(input logic en_n);
    @(posedge clock_in);
    ren_n_out <= en_n;
    @(posedge clock_in);
    out_clk_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    out_clk_out <= 1'b0;
    ren_n_out <= 1'b1;
    repeat (2) @(posedge clock_in);
  endtask : rd_cycle
endmodule : far_side_model
`default_nettype wire

// [testbench/testbench.sv]
// testbench: standard and fall-through runs of the fifo port controller
// assumes far_side_model drives the link side and the axi tasks the registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench import fifo_port_pkg::*;;
  localparam int DEPTH = 16;
  typedef struct packed {logic wen_n; logic [WORD_W-1:0] d; logic [15:0] cnt;} row_t;
  row_t rows [4] = '{'{1'b0, 36'h123456789, 16'h1}, '{1'b1, 36'h0deadbeef, 16'h1},
                     '{1'b0, 36'hf00000001, 16'h2}, '{1'b0, 36'h888888888, 16'h3}};
  logic clock_in, arst_n, mrst_n, ft, pick0, byte_order, sen_n, lo_n, oe_n, in_clk, out_clk, wen_n, ren_n;
  logic oe, empty_n, full_n, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, awready, wready, arready;
  logic [WORD_W-1:0] din, q, exp_w;
  logic pick1, bm, iw, ow, async_input_port_select_n, async_output_port_select_n, ae_n, af_n, hf_n;
  logic [3:0] wstrb;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [WORD_W-1:0] exp_q [$];
  int err_total, check_count;
  // ==========================================================================
  // design and far side
  fifo_port_ctrl #(.DEPTH(DEPTH)) uut (.clock_in(clock_in), .arst_n_in(arst_n), .master_reset_n_in(mrst_n),
    .input_clock_in(in_clk), .output_clock_in(out_clk), .write_enable_n_in(wen_n), .read_enable_n_in(ren_n),
    .input_bus_in(din), .fall_through_serial_in_in(ft), .serial_program_enable_n_in(sen_n),
    .offset_load_strobe_n_in(lo_n), .offset_default_pick0_in(pick0), .offset_default_pick1_in(pick1),
    .bus_match_select_in(bm), .input_width_select_in(iw), .output_width_select_in(ow),
    .byte_order_select_in(byte_order), .async_input_port_select_n_in(async_input_port_select_n), .async_output_port_select_n_in(async_output_port_select_n),
    .output_drive_enable_n_in(oe_n), .output_bus_out(q), .output_bus_oe_out(oe), .empty_flag_n_out(empty_n),
    .full_flag_n_out(full_n), .almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n),
    .half_level_flag_n_out(hf_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  far_side_model far (.clock_in(clock_in), .in_clk_out(in_clk), .out_clk_out(out_clk), .wen_n_out(wen_n),
    .ren_n_out(ren_n), .data_out(din));
  // ==========================================================================
  // tasks
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock_in); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock_in);
      aw_done = aw_done | (awready === 1'b1);
      w_done = w_done | (wready === 1'b1);
      awvalid <= !aw_done;
      wvalid <= !w_done;
    end
    do @(posedge clock_in); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic master_reset(input logic mode);
    @(posedge clock_in);
    mrst_n <= 1'b0;
    ft <= mode;
    repeat (8) @(posedge clock_in);
    mrst_n <= 1'b1;
    repeat (8) @(posedge clock_in);
    ft <= 1'b0;
  endtask : master_reset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // clock, watchdog (run needs about 470 cycles) and sequence
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    err_total++;
    complete_run();
  end
  initial begin
    {arst_n, mrst_n, ft, pick0, byte_order, lo_n, oe_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {sen_n, awaddr, araddr, wdata} = {1'b1, 48'h0};
    {pick1, bm, iw, ow, async_input_port_select_n, async_output_port_select_n, wstrb} = 10'h03f;
    repeat (10) @(posedge clock_in);
    arst_n <= 1'b1;
    master_reset(1'b0);
    `CHK("empty", 1'b0, empty_n)
    `CHK("full", 1'b1, full_n)
    `CHK("bus", 36'h0, q)
    axi_rd(ADDR_EMPTY_OFF);
    `CHK("default", 32'(DEFAULT_OFFSET[0]), rd)
    axi_rd(8'h0c);
    `CHK("unmapped", RESP_SLVERR, rs)
    axi_wr(ADDR_FULL_OFF, 32'h5);
    lo_n <= 1'b1;
    repeat (4) @(posedge clock_in);
    axi_wr(ADDR_FULL_OFF, 32'h9);
    axi_rd(ADDR_FULL_OFF);
    `CHK("offset", 32'h5, rd)
    $display("reset and registers done");
    for (int i = 0; i < 4; i++) begin
      far.wr_cycle(rows[i].wen_n, rows[i].d);
      if (!rows[i].wen_n) exp_q.push_back(rows[i].d);
      axi_rd(ADDR_STATUS);
      `CHK("count", rows[i].cnt, rd[15:0])
    end
    for (int i = 3; i < DEPTH; i++) begin
      far.wr_cycle(1'b0, WORD_W'(i));
      exp_q.push_back(WORD_W'(i));
    end
    far.wr_cycle(1'b0, 36'h555555555);
    axi_rd(ADDR_STATUS);
    `CHK("count", 16'(DEPTH), rd[15:0])
    `CHK("full", 1'b0, full_n)
    `CHK("empty", 1'b0, empty_n)
    `CHK("levels", 3'b000, {ae_n, af_n, hf_n})
    far.rd_cycle(1'b1);
    far.rd_cycle(1'b1);
    `CHK("empty", 1'b1, empty_n)
    far.rd_cycle(1'b0);
    exp_w = exp_q.pop_front();
    `CHK("word", exp_w, q)
    `CHK("full", 1'b0, full_n)
    far.wr_cycle(1'b1, 36'h0);
    far.wr_cycle(1'b1, 36'h0);
    `CHK("full", 1'b1, full_n)
    far.rd_cycle(1'b1);
    `CHK("hold", 36'h123456789, q)
    while (exp_q.size() > 0) begin
      far.rd_cycle(1'b0);
      exp_w = exp_q.pop_front();
      `CHK("word", exp_w, q)
    end
    `CHK("empty", 1'b0, empty_n)
    far.rd_cycle(1'b0);
    `CHK("hold", WORD_W'(DEPTH - 1), q)
    oe_n <= 1'b1;
    repeat (6) @(posedge clock_in);
    `CHK("oe", 1'b0, oe)
    oe_n <= 1'b0;
    repeat (6) @(posedge clock_in);
    `CHK("oe", 1'b1, oe)
    $display("standard mode done");
    pick0 <= 1'b1;
    byte_order <= 1'b1;
    lo_n <= 1'b0;
    master_reset(1'b1);
    `CHK("ready", 2'b10, {empty_n, full_n})
    axi_rd(ADDR_STATUS);
    `CHK("mode", 1'b1, rd[ST_FWFT_BIT])
    sen_n <= 1'b0;
    far.wr_cycle(1'b0, 36'h987654321);
    sen_n <= 1'b1;
    axi_rd(ADDR_EMPTY_OFF);
    `CHK("default", 32'(DEFAULT_OFFSET[1]), rd)
    far.rd_cycle(1'b1);
    far.rd_cycle(1'b1);
    `CHK("early", 36'h0, q)
    far.rd_cycle(1'b1);
    `CHK("fall", 36'h987654321, q)
    `CHK("ready", 1'b0, empty_n)
    far.rd_cycle(1'b0);
    `CHK("ready", 1'b1, empty_n)
    `CHK("hold", 36'h987654321, q)
    $display("fall-through mode done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
